// [design/ssbs_consts.svh]
// constants of the servo stop and brake sequencer
`ifndef SSBS_CONSTS_SVH
`define SSBS_CONSTS_SVH

// ----------------------------------------------------------------
// register map (word index on ADDR)
// ----------------------------------------------------------------
`define SSB_REG_TORQUE_LIMIT 4'h0
`define SSB_REG_SON_WAIT 4'h1
`define SSB_REG_SOFF_WAIT 4'h2
`define SSB_REG_BRAKE_SPEED 4'h3
`define SSB_REG_BRAKE_WAIT 4'h4
`define SSB_REG_OUT_ALLOC 4'h5
`define SSB_REG_STATE 4'h6
`define SSB_REG_SELECT 4'h7
`define SSB_REG_IRQ_STATUS 4'h8
`define SSB_REG_IRQ_MASK 4'h9

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define SSB_TORQUE_RESET 9'h12c
`define SSB_TORQUE_MAX 9'h15e
`define SSB_SON_WAIT_RESET 16'h0000
`define SSB_SOFF_WAIT_RESET 9'h000
`define SSB_BRAKE_SPEED_RESET 7'h64
`define SSB_BRAKE_WAIT_RESET 7'h32
`define SSB_OUT_ALLOC_RESET 12'h000
`define SSB_ALLOC_BRAKE 4'h4

// ----------------------------------------------------------------
// stop selection codes
// ----------------------------------------------------------------
`define SSB_FSEL_DB_DB 2'h1
`define SSB_FSEL_CO_CO 2'h2
`define SSB_LSEL_CO_CO 2'h1
`define SSB_LSEL_RB_ZC 2'h2
`define SSB_LSEL_RB_CO 2'h3
`define SSB_MSEL_DB_DB 3'h1
`define SSB_MSEL_CO_CO 3'h2
`define SSB_MSEL_RB_DB 3'h3
`define SSB_MSEL_RB_CO 3'h4
`define SSB_MSEL_WARN 3'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSB_CLK_PERIOD_PS 5000
`define SSB_MS_PS 1000000000
`define SSB_WAIT_UNIT_MS 10

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define SSB_IRQ_STOP 0
`define SSB_IRQ_BRAKE 1
`define SSB_IRQ_POWER 2
`define SSB_IRQ_WARN 3

`endif

// [design/ssbs_pkg.sv]
// types of the servo stop and brake sequencer
package ssbs_pkg;

  typedef enum logic [7:0] {
    ST_OFF = 8'h01,
    ST_SON_BRK = 8'h02,
    ST_SON_PWR = 8'h04,
    ST_ON = 8'h08,
    ST_SOFF_WAIT = 8'h10,
    ST_REV_BRAKE = 8'h20,
    ST_COAST_DOWN = 8'h40,
    ST_HOLD = 8'h80
  } ssbs_state_type;

  typedef enum logic [1:0] {
    SM_DB = 2'h0,
    SM_COAST = 2'h1,
    SM_REVERSE = 2'h2,
    SM_NONE = 2'h3
  } ssbs_stop_type;

  typedef enum logic [1:0] {
    PS_COAST = 2'h0,
    PS_DB = 2'h1,
    PS_ZERO_CLAMP = 2'h2,
    PS_OPERATE = 2'h3
  } ssbs_post_type;

  typedef struct packed {
    ssbs_stop_type method;
    ssbs_post_type post;
  } ssbs_pair_type;

  typedef struct packed {
    logic power;
    logic brake_release;
    logic db;
    logic zero_clamp;
    logic torque_en;
  } ssbs_drive_type;

endpackage

// [design/ssbs_top.sv]
// servo stop-method selection and holding-brake sequencer
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssbs_consts.svh"

module ssbs_top #(
  parameter int MS_CYCLES = `SSB_MS_PS / `SSB_CLK_PERIOD_PS,
  parameter int PRESC_W = 18
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic SERVO_ON_CMD,
  input wire logic GROUP_ONE_ALARM,
  input wire logic GROUP_TWO_ALARM,
  input wire logic OVERTRAVEL_STATE,
  input wire logic SAFE_STATE,
  input wire logic [1:0] FAULT_STOP_SELECT,
  input wire logic [1:0] LIMIT_STOP_SELECT,
  input wire logic [2:0] MINOR_FAULT_STOP_SELECT,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [15:0] RD_DATA,
  output logic MOTOR_POWER_ON,
  output logic BRAKE_RELEASE_OUT,
  output logic DYNAMIC_BRAKE_STATE,
  output logic ZERO_CLAMP_EN,
  output logic TORQUE_LIMIT_EN,
  output logic [8:0] TORQUE_LIMIT,
  output logic [2:0] OUTPUT_PAIR,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic ssbs_pkg::ssbs_pair_type fault_pair(input logic [1:0] s);
    case (s)
      `SSB_FSEL_DB_DB: fault_pair = '{ssbs_pkg::SM_DB, ssbs_pkg::PS_DB};
      `SSB_FSEL_CO_CO: fault_pair = '{ssbs_pkg::SM_COAST, ssbs_pkg::PS_COAST};
      default: fault_pair = '{ssbs_pkg::SM_DB, ssbs_pkg::PS_COAST};
    endcase
  endfunction

  function automatic ssbs_pkg::ssbs_pair_type limit_pair(input logic [1:0] s);
    case (s)
      `SSB_LSEL_CO_CO: limit_pair = '{ssbs_pkg::SM_COAST, ssbs_pkg::PS_COAST};
      `SSB_LSEL_RB_ZC: limit_pair = '{ssbs_pkg::SM_REVERSE, ssbs_pkg::PS_ZERO_CLAMP};
      `SSB_LSEL_RB_CO: limit_pair = '{ssbs_pkg::SM_REVERSE, ssbs_pkg::PS_COAST};
      default: limit_pair = '{ssbs_pkg::SM_DB, ssbs_pkg::PS_COAST};
    endcase
  endfunction

  function automatic ssbs_pkg::ssbs_pair_type minor_pair(input logic [2:0] s);
    case (s)
      `SSB_MSEL_DB_DB: minor_pair = '{ssbs_pkg::SM_DB, ssbs_pkg::PS_DB};
      `SSB_MSEL_CO_CO: minor_pair = '{ssbs_pkg::SM_COAST, ssbs_pkg::PS_COAST};
      `SSB_MSEL_RB_DB: minor_pair = '{ssbs_pkg::SM_REVERSE, ssbs_pkg::PS_DB};
      `SSB_MSEL_RB_CO: minor_pair = '{ssbs_pkg::SM_REVERSE, ssbs_pkg::PS_COAST};
      `SSB_MSEL_WARN: minor_pair = '{ssbs_pkg::SM_NONE, ssbs_pkg::PS_OPERATE};
      default: minor_pair = '{ssbs_pkg::SM_DB, ssbs_pkg::PS_COAST};
    endcase
  endfunction

  function automatic logic [15:0] ten_ms(input logic [8:0] v);
    ten_ms = 16'({7'h00, v} * 16'(`SSB_WAIT_UNIT_MS));
  endfunction

  // output levels follow from the state being entered, its post-stop mode, its stop method and the alarm
  function automatic ssbs_pkg::ssbs_drive_type drive_of(input ssbs_pkg::ssbs_state_type st,
      input ssbs_pkg::ssbs_post_type post, input ssbs_pkg::ssbs_stop_type meth, input logic alarm);
    drive_of = '0;
    case (st)
      ssbs_pkg::ST_SON_BRK: drive_of.brake_release = 1'b1;
      ssbs_pkg::ST_SON_PWR: drive_of.power = 1'b1;
      ssbs_pkg::ST_ON: begin
        drive_of.power = 1'b1;
        drive_of.brake_release = 1'b1;
      end
      ssbs_pkg::ST_SOFF_WAIT: drive_of.power = 1'b1;
      ssbs_pkg::ST_REV_BRAKE: begin
        drive_of.power = 1'b1;
        drive_of.brake_release = 1'b1;
        drive_of.torque_en = 1'b1;
      end
      ssbs_pkg::ST_COAST_DOWN: begin
        drive_of.brake_release = 1'b1;
        drive_of.db = (meth == ssbs_pkg::SM_DB);
      end
      ssbs_pkg::ST_HOLD: begin
        drive_of.power = (post == ssbs_pkg::PS_ZERO_CLAMP) && !alarm;
        drive_of.zero_clamp = (post == ssbs_pkg::PS_ZERO_CLAMP) && !alarm;
        drive_of.db = (post == ssbs_pkg::PS_DB);
      end
      ssbs_pkg::ST_OFF: drive_of.db = (post == ssbs_pkg::PS_DB);
      default: drive_of = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and reset-time selection capture
  // ----------------------------------------------------------------
  logic [11:0] pin_meta_reg;
  logic [11:0] pin_sync_reg;
  logic [1:0] fault_sel_reg;
  logic [1:0] limit_sel_reg;
  logic [2:0] minor_sel_reg;
  logic son, g1, g2, ot, safe;

  always_ff @(posedge MCLK) begin
    if (CE) begin
      pin_meta_reg <= {MINOR_FAULT_STOP_SELECT, LIMIT_STOP_SELECT, FAULT_STOP_SELECT,
                       SAFE_STATE, OVERTRAVEL_STATE, GROUP_TWO_ALARM, GROUP_ONE_ALARM, SERVO_ON_CMD};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // selection straps must be held through reset; changing them later has no effect
  always_ff @(posedge MCLK) begin
    if (SYS_RST && CE) begin
      fault_sel_reg <= pin_sync_reg[6:5];
      limit_sel_reg <= pin_sync_reg[8:7];
      minor_sel_reg <= pin_sync_reg[11:9];
    end
  end

  assign son = pin_sync_reg[0];
  assign g1 = pin_sync_reg[1];
  assign g2 = pin_sync_reg[2];
  assign ot = pin_sync_reg[3];
  assign safe = pin_sync_reg[4];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0] torque_reg;
  logic [15:0] son_wait_reg;
  logic [8:0] soff_wait_reg;
  logic [6:0] brake_speed_reg;
  logic [6:0] brake_wait_reg;
  logic [11:0] alloc_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic [15:0] rd_data_reg;
  logic wr_ok, rd_ok;

  assign wr_ok = CE && WR_EN;
  assign rd_ok = CE && RD_EN;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      torque_reg <= `SSB_TORQUE_RESET;
      son_wait_reg <= `SSB_SON_WAIT_RESET;
      soff_wait_reg <= `SSB_SOFF_WAIT_RESET;
      brake_speed_reg <= `SSB_BRAKE_SPEED_RESET;
      brake_wait_reg <= `SSB_BRAKE_WAIT_RESET;
      alloc_reg <= `SSB_OUT_ALLOC_RESET;
      irq_mask_reg <= 4'h0;
    end else if (wr_ok) begin
      case (ADDR)
        `SSB_REG_TORQUE_LIMIT: torque_reg <= WR_DATA[8:0];
        `SSB_REG_SON_WAIT: son_wait_reg <= WR_DATA;
        `SSB_REG_SOFF_WAIT: soff_wait_reg <= WR_DATA[8:0];
        `SSB_REG_BRAKE_SPEED: brake_speed_reg <= WR_DATA[6:0];
        `SSB_REG_BRAKE_WAIT: brake_wait_reg <= WR_DATA[6:0];
        `SSB_REG_OUT_ALLOC: alloc_reg <= WR_DATA[11:0];
        `SSB_REG_IRQ_MASK: irq_mask_reg <= WR_DATA[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ssbs_pkg::ssbs_state_type state_reg, state_next;
  ssbs_pkg::ssbs_post_type post_reg, post_next;
  ssbs_pkg::ssbs_stop_type meth_reg, meth_next;
  ssbs_pkg::ssbs_pair_type pair;
  ssbs_pkg::ssbs_drive_type drv_reg, drv_next;
  logic alarm_stop, warn, stop_req, stopped, wait_done;
  logic [15:0] son_mag, wait_target;
  logic [15:0] cnt_ms_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic ms_tick;

  assign warn = g2 && (minor_sel_reg == `SSB_MSEL_WARN);
  assign alarm_stop = g1 || (g2 && !warn);
  assign stop_req = alarm_stop || safe || ot || !son;
  assign stopped = MOTOR_SPEED < {9'h000, brake_speed_reg};
  assign son_mag = son_wait_reg[15] ? 16'(-son_wait_reg) : son_wait_reg;

  always_comb begin
    if (g1 || safe) begin
      pair = fault_pair(fault_sel_reg);
    end else if (g2 && !warn) begin
      pair = minor_pair(minor_sel_reg);
    end else if (ot) begin
      pair = limit_pair(limit_sel_reg);
    end else begin
      pair = fault_pair(fault_sel_reg);
    end
  end

  always_comb begin
    case (state_reg)
      ssbs_pkg::ST_SON_BRK, ssbs_pkg::ST_SON_PWR: wait_target = son_mag;
      ssbs_pkg::ST_SOFF_WAIT: wait_target = ten_ms(soff_wait_reg);
      ssbs_pkg::ST_COAST_DOWN: wait_target = ten_ms({2'h0, brake_wait_reg});
      default: wait_target = 16'h0000;
    endcase
  end
  assign wait_done = cnt_ms_reg >= wait_target;

  always_comb begin
    state_next = state_reg;
    post_next = post_reg;
    meth_next = meth_reg;
    case (state_reg)
      ssbs_pkg::ST_OFF: begin
        if (son && !(alarm_stop || safe || ot)) begin
          post_next = ssbs_pkg::PS_OPERATE;
          if (son_wait_reg[15]) begin
            state_next = ssbs_pkg::ST_SON_PWR;
          end else if (son_wait_reg != 16'h0000) begin
            state_next = ssbs_pkg::ST_SON_BRK;
          end else begin
            state_next = ssbs_pkg::ST_ON;
          end
        end
      end
      ssbs_pkg::ST_SON_BRK, ssbs_pkg::ST_SON_PWR, ssbs_pkg::ST_ON: begin
        if (stop_req) begin
          post_next = pair.post;
          meth_next = pair.method;
          if (stopped) begin
            // brake goes on at once; power waits unless an alarm cut it
            state_next = alarm_stop ? ssbs_pkg::ST_HOLD : ssbs_pkg::ST_SOFF_WAIT;
          end else if (pair.method == ssbs_pkg::SM_REVERSE) begin
            state_next = ssbs_pkg::ST_REV_BRAKE;
          end else begin
            state_next = ssbs_pkg::ST_COAST_DOWN;
          end
        end else if (state_reg != ssbs_pkg::ST_ON && wait_done) begin
          state_next = ssbs_pkg::ST_ON;
        end
      end
      ssbs_pkg::ST_SOFF_WAIT: begin
        if (alarm_stop || wait_done) begin
          state_next = ssbs_pkg::ST_HOLD;
        end
      end
      ssbs_pkg::ST_REV_BRAKE: begin
        // a group-one alarm overrides reverse braking and drops power
        if (g1) begin
          meth_next = ssbs_pkg::SM_DB;
          state_next = ssbs_pkg::ST_COAST_DOWN;
        end else if (stopped) begin
          state_next = ssbs_pkg::ST_HOLD;
        end
      end
      ssbs_pkg::ST_COAST_DOWN: begin
        if (stopped || wait_done) begin
          state_next = ssbs_pkg::ST_HOLD;
        end
      end
      ssbs_pkg::ST_HOLD: begin
        if (!(alarm_stop || safe || ot)) begin
          state_next = ssbs_pkg::ST_OFF;
        end
      end
      default: state_next = ssbs_pkg::ST_OFF;
    endcase
    drv_next = drive_of(state_next, post_next, meth_next, alarm_stop);
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= ssbs_pkg::ST_OFF;
      post_reg <= ssbs_pkg::PS_COAST;
      meth_reg <= ssbs_pkg::SM_DB;
      drv_reg <= '0;
    end else if (CE) begin
      state_reg <= state_next;
      post_reg <= post_next;
      meth_reg <= meth_next;
      drv_reg <= drv_next;
    end
  end

  // millisecond timebase restarts on every state change so each wait is exact
  assign ms_tick = presc_reg == PRESC_W'(MS_CYCLES - 1);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      presc_reg <= '0;
      cnt_ms_reg <= 16'h0000;
    end else if (CE) begin
      if (state_next != state_reg) begin
        presc_reg <= '0;
        cnt_ms_reg <= 16'h0000;
      end else if (ms_tick) begin
        presc_reg <= '0;
        if (!wait_done) begin
          cnt_ms_reg <= cnt_ms_reg + 16'h0001;
        end
      end else begin
        presc_reg <= presc_reg + PRESC_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [8:0] torque_out_reg;
  logic [2:0] pair_reg;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      torque_out_reg <= `SSB_TORQUE_RESET;
      pair_reg <= 3'h0;
    end else if (CE) begin
      // values above the range are clamped rather than passed to the current loop
      torque_out_reg <= (torque_reg > `SSB_TORQUE_MAX) ? `SSB_TORQUE_MAX : torque_reg;
      for (int i = 0; i < 3; i++) begin
        pair_reg[i] <= (alloc_reg[4*i +: 4] == `SSB_ALLOC_BRAKE) && drv_next.brake_release;
      end
    end
  end

  assign MOTOR_POWER_ON = drv_reg.power;
  assign BRAKE_RELEASE_OUT = drv_reg.brake_release;
  assign DYNAMIC_BRAKE_STATE = drv_reg.db;
  assign ZERO_CLAMP_EN = drv_reg.zero_clamp;
  assign TORQUE_LIMIT_EN = drv_reg.torque_en;
  assign TORQUE_LIMIT = torque_out_reg;
  assign OUTPUT_PAIR = pair_reg;

  // ----------------------------------------------------------------
  // interrupts and read-back
  // ----------------------------------------------------------------
  logic [3:0] evt;
  logic irq_clr;

  always_comb begin
    evt = 4'h0;
    evt[`SSB_IRQ_STOP] = CE && (state_reg == ssbs_pkg::ST_ON) && (state_next != ssbs_pkg::ST_ON);
    evt[`SSB_IRQ_BRAKE] = CE && drv_reg.brake_release && !drv_next.brake_release;
    evt[`SSB_IRQ_POWER] = CE && drv_reg.power && !drv_next.power;
    evt[`SSB_IRQ_WARN] = CE && warn;
  end
  assign irq_clr = rd_ok && (ADDR == `SSB_REG_IRQ_STATUS);

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (irq_clr ? 4'h0 : irq_status_reg) | evt;
    end
  end

  assign IRQ = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rd_data_reg <= 16'h0000;
    end else if (rd_ok) begin
      case (ADDR)
        `SSB_REG_TORQUE_LIMIT: rd_data_reg <= {7'h00, torque_reg};
        `SSB_REG_SON_WAIT: rd_data_reg <= son_wait_reg;
        `SSB_REG_SOFF_WAIT: rd_data_reg <= {7'h00, soff_wait_reg};
        `SSB_REG_BRAKE_SPEED: rd_data_reg <= {9'h000, brake_speed_reg};
        `SSB_REG_BRAKE_WAIT: rd_data_reg <= {9'h000, brake_wait_reg};
        `SSB_REG_OUT_ALLOC: rd_data_reg <= {4'h0, alloc_reg};
        `SSB_REG_STATE: rd_data_reg <= {4'h0, post_reg, meth_reg, state_reg};
        `SSB_REG_SELECT: rd_data_reg <= {9'h000, minor_sel_reg, limit_sel_reg, fault_sel_reg};
        `SSB_REG_IRQ_STATUS: rd_data_reg <= {12'h000, irq_status_reg};
        `SSB_REG_IRQ_MASK: rd_data_reg <= {12'h000, irq_mask_reg};
        default: rd_data_reg <= 16'h0000;
      endcase
    end else if (CE) begin
      rd_data_reg <= 16'h0000;
    end
  end

  assign RD_DATA = rd_data_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_alarm_power_cut: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && g1 && state_reg != ssbs_pkg::ST_OFF |=> !MOTOR_POWER_ON)
    else $error("power still on after group-one alarm");

  a_stopped_brake_drop: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_ON && stop_req && stopped |=> !BRAKE_RELEASE_OUT)
    else $error("brake release kept after stop while stopped");

  a_soff_power_held: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_ON && !son && !alarm_stop && !safe && !ot && stopped
      |=> MOTOR_POWER_ON && state_reg == ssbs_pkg::ST_SOFF_WAIT)
    else $error("servo-off wait skipped");

  a_son_brake_first: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_OFF && state_next == ssbs_pkg::ST_SON_BRK
      |=> BRAKE_RELEASE_OUT && !MOTOR_POWER_ON)
    else $error("positive servo-on wait order wrong");

  a_son_power_first: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_OFF && son && !alarm_stop && !safe && !ot && son_wait_reg[15]
      |=> MOTOR_POWER_ON && !BRAKE_RELEASE_OUT)
    else $error("negative servo-on wait order wrong");

  a_zero_clamp_power: assert property (@(posedge MCLK) disable iff (SYS_RST)
    ZERO_CLAMP_EN |-> MOTOR_POWER_ON && !DYNAMIC_BRAKE_STATE)
    else $error("zero clamp without power");

  a_db_no_power: assert property (@(posedge MCLK) disable iff (SYS_RST)
    DYNAMIC_BRAKE_STATE |-> !MOTOR_POWER_ON && !ZERO_CLAMP_EN)
    else $error("dynamic brake with power on");

  a_coast_free: assert property (@(posedge MCLK) disable iff (SYS_RST)
    state_reg == ssbs_pkg::ST_HOLD && post_reg == ssbs_pkg::PS_COAST
      |-> !MOTOR_POWER_ON && !DYNAMIC_BRAKE_STATE)
    else $error("coasting state still drives motor");

  a_speed_brake: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_COAST_DOWN && stopped |=> !BRAKE_RELEASE_OUT)
    else $error("brake not engaged below speed threshold");

  a_torque_capped: assert property (@(posedge MCLK) disable iff (SYS_RST)
    TORQUE_LIMIT_EN |-> TORQUE_LIMIT <= `SSB_TORQUE_MAX && MOTOR_POWER_ON)
    else $error("reverse brake torque limit out of range");

  a_pair_route: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && alloc_reg[3:0] == `SSB_ALLOC_BRAKE |=> OUTPUT_PAIR[0] == BRAKE_RELEASE_OUT)
    else $error("output pair does not follow brake release");

  a_select_frozen: assert property (@(posedge MCLK) disable iff (SYS_RST)
    1'b1 |=> $stable(fault_sel_reg) && $stable(limit_sel_reg) && $stable(minor_sel_reg))
    else $error("stop selection changed outside reset");

  a_brake_wait_bound: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && state_reg == ssbs_pkg::ST_COAST_DOWN && wait_done |=> !BRAKE_RELEASE_OUT)
    else $error("brake not engaged after waiting time");

  c_reverse_brake: cover property (@(posedge MCLK) state_reg == ssbs_pkg::ST_REV_BRAKE ##1
    state_reg == ssbs_pkg::ST_HOLD);
  c_zero_clamp: cover property (@(posedge MCLK) ZERO_CLAMP_EN);
  c_coast_timeout: cover property (@(posedge MCLK) state_reg == ssbs_pkg::ST_COAST_DOWN && wait_done && !stopped);
  c_son_neg: cover property (@(posedge MCLK) state_reg == ssbs_pkg::ST_SON_PWR ##1 state_reg == ssbs_pkg::ST_ON);

endmodule

`default_nettype wire

// [testbench/ssbs_host_model.sv]
// host motion controller model that issues servo on and off
`timescale 1ns/1ps
`default_nettype none
module ssbs_host_model #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic servo_req,
  output logic SERVO_ON_CMD,
  output logic motion_ok
);
  int count_reg;
  // motion stays held back until the brake has had time to release
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !servo_req) begin
      count_reg <= 0;
      motion_ok <= 1'b0;
    end else if (count_reg < SETTLE_CYCLES) begin
      count_reg <= count_reg + 1;
    end else begin
      motion_ok <= 1'b1;
    end
  end
  always_ff @(posedge MCLK) begin
    SERVO_ON_CMD <= servo_req && !SYS_RST;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the stop and brake sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic MCLK = 0, SYS_RST = 1, ce = 1, req = 0, g1 = 0, g2 = 0, ot = 0, safe = 0, wr_en = 0, rd_en = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, speed = 16'h0000, rv, rdata;
  logic son, motion_ok, pwr, brk, db, zc, tle, irq;
  logic [8:0] tl;
  logic [2:0] pair;
  logic [1:0] lsel = 2'h0;
  logic [2:0] msel = 3'h0;
  int num_errors = 0, n_compared = 0;
  always #2.5 MCLK = ~MCLK;
  // settle spans 50 ms plus a 2 ms brake release time at 4 cycles per ms
  ssbs_host_model #(.SETTLE_CYCLES(208)) ssbs_host_model_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .servo_req(req),
    .SERVO_ON_CMD(son), .motion_ok(motion_ok));
  // a small ms count keeps the waits short
  ssbs_top #(.MS_CYCLES(4)) ssbs_top_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(ce), .SERVO_ON_CMD(son),
    .GROUP_ONE_ALARM(g1), .GROUP_TWO_ALARM(g2), .OVERTRAVEL_STATE(ot), .SAFE_STATE(safe),
    .FAULT_STOP_SELECT(2'h0), .LIMIT_STOP_SELECT(lsel), .MINOR_FAULT_STOP_SELECT(msel), .MOTOR_SPEED(speed),
    .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rdata), .MOTOR_POWER_ON(pwr),
    .BRAKE_RELEASE_OUT(brk), .DYNAMIC_BRAKE_STATE(db), .ZERO_CLAMP_EN(zc), .TORQUE_LIMIT_EN(tle),
    .TORQUE_LIMIT(tl), .OUTPUT_PAIR(pair), .IRQ(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge MCLK);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge MCLK);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge MCLK);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rd(4'h0, rv); chk(rv, 16'h012c);
    rd(4'h3, rv); chk(rv, 16'h0064);
    rd(4'h4, rv); chk(rv, 16'h0032);
    rd(4'ha, rv); chk(rv, 16'h0000);
    chk({7'h00, tl}, 16'h012c);
    $display("test reset values done");
    wr(4'h5, 16'h0404);
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0001);
    wr(4'h9, 16'h000f);
    @(posedge MCLK) req <= 1'b1;
    cyc(5); chk({11'h000, pwr, brk, pair}, 16'h000d);
    cyc(12); chk({11'h000, pwr, brk, pair}, 16'h001d);
    @(posedge MCLK) req <= 1'b0;
    cyc(5); chk({11'h000, pwr, brk, pair}, 16'h0010);
    cyc(50); chk({14'h0000, pwr, brk}, 16'h0000);
    chk({15'h0000, irq}, 16'h0001);
    rd(4'h8, rv); chk(rv, 16'h0007);
    cyc(2); chk({15'h0000, irq}, 16'h0000);
    $display("test servo on and off done");
    @(posedge MCLK) speed <= 16'h01f4;
    req <= 1'b1;
    cyc(20); chk({14'h0000, pwr, brk}, 16'h0003);
    chk({15'h0000, motion_ok}, 16'h0000);
    @(posedge MCLK) g1 <= 1'b1;
    cyc(6); chk({13'h0000, pwr, brk, db}, 16'h0003);
    @(posedge MCLK) speed <= 16'h0000;
    cyc(6); chk({15'h0000, brk}, 16'h0000);
    $display("test alarm stop done");
    // strobes with the enable low must be lost
    @(posedge MCLK) ce <= 1'b0;
    wr(4'h0, 16'h0020);
    @(posedge MCLK) ce <= 1'b1;
    rd(4'h0, rv); chk(rv, 16'h012c);
    wr(4'h0, 16'h01ff);
    cyc(2); chk({7'h00, tl}, 16'h015e);
    $display("test enable and torque limit done");
    // second reset with new straps: reverse brake to zero clamp, group-two as warning
    @(posedge MCLK) begin
      SYS_RST <= 1'b1;
      g1 <= 1'b0;
      lsel <= 2'h2;
      msel <= 3'h5;
    end
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    cyc(6); chk({14'h0000, pwr, brk}, 16'h0003);
    rd(4'h7, rv); chk(rv, 16'h0058);
    @(posedge MCLK) g2 <= 1'b1;
    cyc(4); chk({14'h0000, pwr, brk}, 16'h0003);
    rd(4'h8, rv); chk(rv, 16'h0008);
    @(posedge MCLK) begin
      ot <= 1'b1;
      speed <= 16'h01f4;
    end
    cyc(5); chk({13'h0000, pwr, brk, tle}, 16'h0007);
    chk({7'h00, tl}, 16'h012c);
    @(posedge MCLK) speed <= 16'h0000;
    cyc(3); chk({12'h000, pwr, brk, zc, tle}, 16'h000a);
    wr(4'h1, 16'hfffe);
    @(posedge MCLK) ot <= 1'b0;
    cyc(5); chk({14'h0000, pwr, brk}, 16'h0002);
    cyc(15); chk({14'h0000, pwr, brk}, 16'h0003);
    cyc(220); chk({15'h0000, motion_ok}, 16'h0001);
    $display("test overtravel and negative wait done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
